// [logic/spco_pkg.sv]
package spco_pkg;
  // register map
  localparam logic [3:0] EXT_CTRL_ADDR = 4'hD;
  localparam int EXT_FREQ_SELECT_FIELD_HI = 3;
  localparam int EXT_FREQ_SELECT_FIELD_LO = 2;
  localparam int EXT_ZERO_BIT = 5;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h0C;
  localparam logic [7:0] REG_RESET = 8'h00;
  // halt bit lives in control register F
  localparam logic [3:0] CTRL_ADDR = 4'hF;
  localparam int CTRL_HALT_BIT = 1;
  // mode codes
  localparam logic [3:0] MODE_WRITE = 4'h1;
  localparam logic [3:0] MODE_READ = 4'h9;
  // frequency selections
  localparam logic [1:0] FREQ_SELECT_FIELD_32K = 2'h0;
  localparam logic [1:0] FREQ_SELECT_FIELD_1K = 2'h1;
  localparam logic [1:0] FREQ_SELECT_FIELD_1HZ = 2'h2;
  localparam logic [1:0] FREQ_SELECT_FIELD_GATED = 2'h3;
  // 16-bit prescaler taps: 65536 Hz toggles give 32768 Hz from a 65536 Hz tick
  localparam real CLK_HZ = 200.0e6;
  localparam real BASE_HZ = 65536.0;
  localparam int TICK_CYCLES = int'(CLK_HZ / BASE_HZ);
  localparam int PRE_W = 16;
  localparam int TAP_32K = 0;
  localparam int TAP_1K = 5;
  localparam int TAP_1HZ = 15;
  localparam int BIT_LAST = 7;
  typedef enum logic [1:0] {SPCO_IDLE, SPCO_HEAD, SPCO_DATA, SPCO_SKIP} spco_state_t;
endpackage : spco_pkg

// [logic/spco_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser; the first stage is read only by the second
module spco_sync (
  // clock
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic d,
  output logic q
);
  logic [1:0] s_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= 2'h0;
    end else if (ce) begin
      s_reg <= {s_reg[0], d};
    end
  end
  assign q = s_reg[1];
endmodule : spco_sync

// [logic/spco_top.sv]
`timescale 1ns/1ps
// Function
// - select 00/01/10 gives 32768 Hz, 1024 Hz, 1 Hz push-pull regardless of the enable pin.
// - select 11 gives 32768 Hz with the enable pin high and high impedance with it low.
// - only select 11 with the enable pin low turns the clock output off.
// - reset sets both select bits to one.
// - while the halt bit is one, 1 Hz output is held low but the fast rates still run.
// - address, mode and data travel most significant bit first.
// - the address advances after every byte and wraps from F to 0.
// - a byte cut short by chip enable falling is not written.
// - mode 1h writes and mode 9h reads.
// - any other mode ignores the rest of the transfer with data released.
module spco_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CLK_EN,
  // serial port
  input wire logic CHIP_ENABLE,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_DATA_IO_IN,
  output logic SERIAL_DATA_IO_OUT,
  output logic SERIAL_DATA_IO_OE_N,
  // clock output
  input wire logic CLOCK_OUT_ENABLE_PIN,
  output logic CLOCK_OUT_PIN,
  output logic CLOCK_OUT_PIN_OE_N
);
  logic ce_s;
  logic sck_s;
  logic din_s;
  logic foe_s;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // CHIP_ENABLE, SERIAL_CLK, SERIAL_DATA_IO_IN and CLOCK_OUT_ENABLE_PIN pass two flops before they are read; CLK_EN and RST do not
  spco_sync u_sync_ce (
    .clk(CLOCK),
    .rst(RST),
    .ce(CLK_EN),
    .d(CHIP_ENABLE),
    .q(ce_s)
  );

  spco_sync u_sync_sck (
    .clk(CLOCK),
    .rst(RST),
    .ce(CLK_EN),
    .d(SERIAL_CLK),
    .q(sck_s)
  );

  spco_sync u_sync_din (
    .clk(CLOCK),
    .rst(RST),
    .ce(CLK_EN),
    .d(SERIAL_DATA_IO_IN),
    .q(din_s)
  );

  spco_sync u_sync_foe (
    .clk(CLOCK),
    .rst(RST),
    .ce(CLK_EN),
    .d(CLOCK_OUT_ENABLE_PIN),
    .q(foe_s)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    spco_pkg::spco_state_t st;
    logic sck_d;
    logic [2:0] bitn;
    logic [7:0] shift;
    logic [3:0] addr;
    logic rd;
    logic [15:0][7:0] regs;
    logic [15:0] tick_cnt;
    logic [spco_pkg::PRE_W-1:0] pre;
    logic dout;
    logic doe_n;
    logic clock_out_pin;
    logic clock_out_pin_oe_n;
  } spco_regs_t;

  spco_regs_t s_reg;
  spco_regs_t s_next;

  logic [1:0] freq_select_field;
  logic halted;
  assign freq_select_field = {s_reg.regs[spco_pkg::EXT_CTRL_ADDR][spco_pkg::EXT_FREQ_SELECT_FIELD_HI],
                 s_reg.regs[spco_pkg::EXT_CTRL_ADDR][spco_pkg::EXT_FREQ_SELECT_FIELD_LO]};
  assign halted = s_reg.regs[spco_pkg::CTRL_ADDR][spco_pkg::CTRL_HALT_BIT];

  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic [7:0] sh;
    sck_rise = sck_s & ~s_reg.sck_d;
    sck_fall = ~sck_s & s_reg.sck_d;
    sh = {s_reg.shift[6:0], din_s};
    s_next = s_reg;
    s_next.sck_d = sck_s;

    // ----------------------------------------
    // frequency prescaler
    // ----------------------------------------
    if (s_reg.tick_cnt == 16'(spco_pkg::TICK_CYCLES - 1)) begin
      s_next.tick_cnt = 16'h0000;
      s_next.pre = s_reg.pre + 16'h0001;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
    end

    // ----------------------------------------
    // clock output select
    // ----------------------------------------
    s_next.clock_out_pin_oe_n = 1'b0;
    unique case (freq_select_field)
      spco_pkg::FREQ_SELECT_FIELD_32K: s_next.clock_out_pin = s_reg.pre[spco_pkg::TAP_32K];
      spco_pkg::FREQ_SELECT_FIELD_1K: s_next.clock_out_pin = s_reg.pre[spco_pkg::TAP_1K];
      spco_pkg::FREQ_SELECT_FIELD_1HZ: s_next.clock_out_pin = halted ? 1'b0 : s_reg.pre[spco_pkg::TAP_1HZ];
      spco_pkg::FREQ_SELECT_FIELD_GATED: begin
        s_next.clock_out_pin = s_reg.pre[spco_pkg::TAP_32K];
        s_next.clock_out_pin_oe_n = ~foe_s;
      end
    endcase

    // ----------------------------------------
    // serial port
    // ----------------------------------------
    if (!ce_s) begin
      // a partial byte is dropped here, never written
      s_next.st = spco_pkg::SPCO_IDLE;
      s_next.doe_n = 1'b1;
      s_next.bitn = 3'h0;
    end else begin
      unique case (s_reg.st)
        spco_pkg::SPCO_IDLE: begin
          s_next.st = spco_pkg::SPCO_HEAD;
          s_next.bitn = 3'h0;
        end
        spco_pkg::SPCO_HEAD: if (sck_rise) begin
          s_next.shift = sh;
          s_next.bitn = s_reg.bitn + 3'h1;
          if (s_reg.bitn == 3'(spco_pkg::BIT_LAST)) begin
            s_next.addr = sh[7:4];
            if (sh[3:0] == spco_pkg::MODE_WRITE) begin
              s_next.st = spco_pkg::SPCO_DATA;
              s_next.rd = 1'b0;
            end else if (sh[3:0] == spco_pkg::MODE_READ) begin
              s_next.st = spco_pkg::SPCO_DATA;
              s_next.rd = 1'b1;
              s_next.shift = s_reg.regs[sh[7:4]];
            end else begin
              s_next.st = spco_pkg::SPCO_SKIP;
            end
          end
        end
        spco_pkg::SPCO_DATA: begin
          if (s_reg.rd) begin
            // drive on falling edge so the host samples on rising
            if (sck_fall) begin
              s_next.dout = s_reg.shift[7];
              s_next.doe_n = 1'b0;
            end
            if (sck_rise) begin
              s_next.shift = {s_reg.shift[6:0], 1'b0};
              s_next.bitn = s_reg.bitn + 3'h1;
              if (s_reg.bitn == 3'(spco_pkg::BIT_LAST)) begin
                s_next.addr = s_reg.addr + 4'h1;
                s_next.shift = s_reg.regs[s_reg.addr + 4'h1];
              end
            end
          end else if (sck_rise) begin
            s_next.shift = sh;
            s_next.bitn = s_reg.bitn + 3'h1;
            if (s_reg.bitn == 3'(spco_pkg::BIT_LAST)) begin
              if (s_reg.addr == spco_pkg::EXT_CTRL_ADDR) begin
                s_next.regs[s_reg.addr] = sh & ~(8'h01 << spco_pkg::EXT_ZERO_BIT);
              end else begin
                s_next.regs[s_reg.addr] = sh;
              end
              s_next.addr = s_reg.addr + 4'h1;
            end
          end
        end
        spco_pkg::SPCO_SKIP: s_next.doe_n = 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // low clock enable freezes every field, prescaler included
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_reg <= '0;
      s_reg.st <= spco_pkg::SPCO_IDLE;
      s_reg.doe_n <= 1'b1;
      s_reg.regs[spco_pkg::EXT_CTRL_ADDR] <= spco_pkg::EXT_CTRL_RESET;
    end else if (CLK_EN) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign SERIAL_DATA_IO_OUT = s_reg.dout;
  assign SERIAL_DATA_IO_OE_N = s_reg.doe_n;
  assign CLOCK_OUT_PIN = s_reg.clock_out_pin;
  assign CLOCK_OUT_PIN_OE_N = s_reg.clock_out_pin_oe_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_head_done;
    CLK_EN && ce_s && s_reg.st == spco_pkg::SPCO_HEAD && sck_s && !s_reg.sck_d
      && s_reg.bitn == 3'h7;
  endsequence

  a_oe_only_gated: assert property (CLK_EN && !(freq_select_field == spco_pkg::FREQ_SELECT_FIELD_GATED && !foe_s)
    |=> !CLOCK_OUT_PIN_OE_N) else $error("clock out off in a driven combination");
  a_gated_off: assert property (CLK_EN && freq_select_field == spco_pkg::FREQ_SELECT_FIELD_GATED && !foe_s
    |=> CLOCK_OUT_PIN_OE_N) else $error("clock out not released");
  a_gated_on: assert property (CLK_EN && freq_select_field == spco_pkg::FREQ_SELECT_FIELD_GATED && foe_s
    |=> !CLOCK_OUT_PIN_OE_N) else $error("gated clock out not driven");
  a_halt_1hz: assert property (CLK_EN && freq_select_field == spco_pkg::FREQ_SELECT_FIELD_1HZ && halted
    |=> !CLOCK_OUT_PIN) else $error("1 Hz not held while halted");
  a_halt_fast: assert property (CLK_EN && freq_select_field == spco_pkg::FREQ_SELECT_FIELD_32K && halted
    |=> CLOCK_OUT_PIN == $past(s_reg.pre[spco_pkg::TAP_32K]))
    else $error("fast clock stopped while halted");
  a_reset_sel: assert property ($past(RST) && !RST |-> freq_select_field == spco_pkg::FREQ_SELECT_FIELD_GATED)
    else $error("select bits not set by reset");
  a_ce_low_rel: assert property (CLK_EN && !ce_s
    |=> SERIAL_DATA_IO_OE_N && s_reg.st == spco_pkg::SPCO_IDLE)
    else $error("data pin driven with chip enable low");
  a_bad_mode: assert property (s_head_done
    ##0 ({s_reg.shift[6:0], din_s} & 8'h0F) != 8'h01
    ##0 ({s_reg.shift[6:0], din_s} & 8'h0F) != 8'h09
    |=> s_reg.st == spco_pkg::SPCO_SKIP) else $error("unknown mode not skipped");
  a_read_mode: assert property (s_head_done ##0 din_s && s_reg.shift[2:0] == 3'h4
    |=> s_reg.st == spco_pkg::SPCO_DATA && s_reg.rd) else $error("read mode missed");
  a_write_quiet: assert property (s_reg.st == spco_pkg::SPCO_DATA && !s_reg.rd
    |-> SERIAL_DATA_IO_OE_N) else $error("data driven during write");
  a_head_quiet: assert property (s_reg.st == spco_pkg::SPCO_HEAD |-> SERIAL_DATA_IO_OE_N)
    else $error("data driven during header");
  a_freeze_hold: assert property (!CLK_EN |=> s_reg == $past(s_reg))
    else $error("state moved with clock enable low");
  a_write_mode: assert property (s_head_done ##0 din_s && s_reg.shift[2:0] == 3'h0
    |=> s_reg.st == spco_pkg::SPCO_DATA && !s_reg.rd) else $error("write mode missed");
  a_skip_quiet: assert property (s_reg.st == spco_pkg::SPCO_SKIP |-> SERIAL_DATA_IO_OE_N)
    else $error("data driven in skip");
  a_addr_wrap: assert property (CLK_EN && ce_s && s_reg.st == spco_pkg::SPCO_DATA && sck_s
    && !s_reg.sck_d && s_reg.bitn == 3'h7 && s_reg.addr == 4'hF
    |=> s_reg.addr == 4'h0) else $error("address did not wrap");
endmodule : spco_top

// [bench/spco_host.sv]
`timescale 1ns/1ps
// -------------------------------------------
// host model; link clock idles low between frames
// -------------------------------------------
module spco_host (
  // clock
  input wire logic clk,
  // serial port
  output logic ce,
  output logic sclk,
  output wire logic din,
  input wire logic dout,
  input wire logic doe_n
);
  logic h_oe = 0;
  logic h_d = 0;
  logic flt = 0;
  logic [7:0] rd_byte;
  logic rd_drv;
  event rd_ev;
  initial begin
    ce = 0;
    sclk = 0;
  end
  // a released line wobbles so a stale level never passes for data
  always @(posedge clk) flt <= ~flt;
  assign din = h_oe ? h_d : (!doe_n ? dout : flt);
  task automatic frame(input logic [3:0] a, input logic [3:0] m, input logic [7:0] wd[$],
                       input int nb);
    logic [7:0] hdr;
    int j;
    hdr = {a, m};
    @(posedge clk) #1 ce = 1;
    repeat (13) @(posedge clk);
    for (int i = 0; i < 8 + nb; i++) begin
      #1 sclk = 0;
      j = i - 8;
      h_oe = (i < 8) || (m == spco_pkg::MODE_WRITE);
      if (i < 8) h_d = hdr[7 - i];
      else if (h_oe) h_d = wd[j / 8][7 - j % 8];
      repeat (13) @(posedge clk);
      #1 sclk = 1;
      if (i >= 8 && !h_oe) begin
        rd_byte[7 - j % 8] = din;
        rd_drv = (j % 8 == 0) ? !doe_n : (rd_drv | !doe_n);
        if (j % 8 == 7) -> rd_ev;
      end
      repeat (12) @(posedge clk);
    end
    #1 sclk = 0;
    h_oe = 0;
    repeat (13) @(posedge clk);
    #1 ce = 0;
    repeat (25) @(posedge clk);
  endtask : frame
endmodule : spco_host

// [bench/spco_top_bench.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t ns got %h want %h", $time, (a), (e)); end end
module spco_top_bench;
  logic clk = 0;
  logic rst = 1;
  logic fo_en = 1;
  wire ce, sclk, din, dout, doe_n, fo, fo_oe_n;
  int n_fail = 0;
  int check_count = 0;
  int p;
  logic [16:0] exp_q[$];
  logic [16:0] w;
  logic [7:0] r0, r1, rf, v;
  always #2.5 clk = ~clk;
  spco_top DUT (.CLOCK(clk), .RST(rst), .CLK_EN(1'b1), .CHIP_ENABLE(ce), .SERIAL_CLK(sclk),
    .SERIAL_DATA_IO_IN(din), .SERIAL_DATA_IO_OUT(dout), .SERIAL_DATA_IO_OE_N(doe_n),
    .CLOCK_OUT_ENABLE_PIN(fo_en), .CLOCK_OUT_PIN(fo), .CLOCK_OUT_PIN_OE_N(fo_oe_n));
  spco_host host (.clk(clk), .ce(ce), .sclk(sclk), .din(din), .dout(dout), .doe_n(doe_n));
  // -------------------------------------------
  // tasks
  // -------------------------------------------
  task automatic rd(input logic [3:0] a, input logic [3:0] m, input logic [7:0] e[$],
                    input logic [7:0] mk);
    foreach (e[i]) exp_q.push_back({mk, m == spco_pkg::MODE_READ, e[i] & mk});
    host.frame(a, m, e, 8 * e.size());
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
    host.frame(a, spco_pkg::MODE_WRITE, d, 8 * d.size());
  endtask : wr
  // divider is approximate, so the period gets a small window
  task automatic period;
    realtime t0;
    @(posedge fo);
    t0 = $realtime;
    @(posedge fo);
    p = int'(($realtime - t0) / 5.0);
  endtask : period
  task automatic conclude;
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  always @(host.rd_ev) begin
    w = exp_q.pop_front();
    `CHK({host.rd_drv, host.rd_byte & w[16:9]}, w[8:0])
  end
  initial begin
    #480us;
    n_fail++;
    conclude();
  end
  initial begin
    void'($urandom(32'hD19EE937));
    repeat (6) @(posedge clk);
    #1 rst = 0;
    repeat (5) @(posedge clk);
    period();
    `CHK(p > 6000 && p < 6200, 1'b1)
    `CHK(fo_oe_n, 1'b0)
    rd(spco_pkg::EXT_CTRL_ADDR, spco_pkg::MODE_READ, '{spco_pkg::EXT_CTRL_RESET}, 8'hFF);
    @(posedge clk) #1 fo_en = 0;
    repeat (8) @(posedge clk);
    `CHK(fo_oe_n, 1'b1)
    for (int s = 0; s < 3; s++) begin
      v = 8'($urandom & 8'h53) | 8'(s << 2);
      wr(spco_pkg::EXT_CTRL_ADDR, '{v});
      `CHK(fo_oe_n, 1'b0)
      rd(spco_pkg::EXT_CTRL_ADDR, spco_pkg::MODE_READ, '{v}, 8'hFF);
      if (s == 2) begin
        // halt set with 1 Hz selected must keep the pin low
        wr(spco_pkg::CTRL_ADDR, '{8'h02});
        repeat (20) @(posedge clk);
        `CHK(fo, 1'b0)
        `CHK(fo_oe_n, 1'b0)
      end
      if (s == 0) begin
        period();
        `CHK(p > 6000 && p < 6200, 1'b1)
      end
    end
    r0 = 8'($urandom);
    r1 = 8'($urandom);
    rf = 8'($urandom);
    wr(4'hF, '{rf, r0, r1});
    rd(4'hF, spco_pkg::MODE_READ, '{rf, r0, r1}, 8'hFF);
    host.frame(4'h1, spco_pkg::MODE_WRITE, '{~r1}, 4);
    rd(4'h1, spco_pkg::MODE_READ, '{r1}, 8'hFF);
    `CHK(doe_n, 1'b1)
    for (int m = 0; m < 16; m++) begin
      if (m != 1) rd(4'h0, 4'(m), '{r0}, (m == 9) ? 8'hFF : 8'h00);
    end
    wait (exp_q.size() == 0);
    conclude();
  end
endmodule : spco_top_bench
